// ==== hw/mtl_regs.svh ====
// Constants of the two-level address translation unit.
// Assumes one core clock and that the core issues maintenance through its coprocessor port.
`ifndef MTL_REGS_SVH
`define MTL_REGS_SVH
`define MTL_UTLB_N 32
`define MTL_SETS 32
`define MTL_LOCK_N 4
`define MTL_MASK_4K 20'hf_ffff
`define MTL_MASK_64K 20'hf_fff0
`define MTL_MASK_1M 20'hf_ff00
`define MTL_MASK_16M 20'hf_f000
`define MTL_DACR_RST 32'h0000_0000
`define MTL_ASID_RST 8'h00
`define MTL_TTB_RST 32'h0000_0000
`define MTL_TTB_WB 0
`define MTL_TTB_WDIS 1
`define MTL_L1_SUPER 18
`define MTL_L1_NG 17
`define MTL_L1_APX 15
`define MTL_L2_NG 11
`define MTL_L2_APX 9
`endif

// ==== hw/mtl_pkg.sv ====
// Types of the two-level address translation unit.
// Assumes the constants header is included by the design file.
package mtl_pkg;
    typedef enum logic [1:0] {
        MTL_SZ_4K = 2'h0,
        MTL_SZ_64K = 2'h1,
        MTL_SZ_1M = 2'h2,
        MTL_SZ_16M = 2'h3
    } mtl_size_t;
    typedef enum logic [2:0] {
        MTL_IDLE = 3'h0,
        MTL_MAIN = 3'h1,
        MTL_WAIT1 = 3'h2,
        MTL_WALK2 = 3'h3,
        MTL_WAIT2 = 3'h4
    } mtl_state_t;
    typedef enum logic [2:0] {
        MTL_OP_ASID = 3'h0,
        MTL_OP_DOMAIN = 3'h1,
        MTL_OP_TTB = 3'h2,
        MTL_OP_INV_ALL = 3'h3,
        MTL_OP_INV_ASID = 3'h4,
        MTL_OP_LOCK_MODE = 3'h5,
        MTL_OP_UNLOCK = 3'h6,
        MTL_OP_NOP = 3'h7
    } mtl_cpop_t;
    typedef struct packed {
        logic [19:0] vtag;
        logic [19:0] ptag;
        mtl_size_t size;
        logic [3:0] dom;
        logic [1:0] ap;
        logic apx;
        logic glob;
        logic nstag;
        logic [7:0] asid;
        logic cacheable;
    } mtl_entry_t;
    typedef struct packed {
        logic [31:0] va;
        logic priv;
        logic wr;
        logic ns;
    } mtl_req_t;
    typedef struct packed {
        logic side;
        logic abort;
        logic cacheable;
        logic [31:0] pa;
    } mtl_rsp_t;
endpackage

// ==== hw/mtl_mmu.sv ====
// Two-level address translation unit with hardware table walk.
// Assumes requesters hold a request until its answer and that walk reads are answered in order.
`timescale 1ns/1ps
`include "mtl_regs.svh"
module mtl_mmu (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic i_valid,
    input wire mtl_pkg::mtl_req_t i_req,
    input wire logic d_valid,
    input wire mtl_pkg::mtl_req_t d_req,
    input wire logic cp_valid,
    input wire mtl_pkg::mtl_cpop_t cp_op,
    input wire logic [31:0] cp_wdata,
    input wire logic walk_rvalid,
    input wire logic [31:0] walk_rdata,
    input wire logic walk_err,
    output logic busy,
    output logic rsp_valid,
    output mtl_pkg::mtl_rsp_t rsp,
    output logic walk_req,
    output logic [31:0] walk_addr,
    output logic walk_cacheable
);
    // ----------------------------------------
    // Entry helpers.
    // ----------------------------------------
    function automatic logic [19:0] mask_f(input mtl_pkg::mtl_size_t s);
        case (s)
            mtl_pkg::MTL_SZ_4K: mask_f = `MTL_MASK_4K;
            mtl_pkg::MTL_SZ_64K: mask_f = `MTL_MASK_64K;
            mtl_pkg::MTL_SZ_1M: mask_f = `MTL_MASK_1M;
            default: mask_f = `MTL_MASK_16M;
        endcase
    endfunction
    function automatic logic hit_f(input mtl_pkg::mtl_entry_t e, input mtl_pkg::mtl_req_t r, input logic [7:0] id);
        hit_f = (((e.vtag ^ r.va[31:12]) & mask_f(e.size)) == 20'h0_0000) && (e.nstag == r.ns)
            && (e.glob || (e.asid == id));
    endfunction
    function automatic logic [31:0] pa_f(input mtl_pkg::mtl_entry_t e, input logic [31:0] va);
        pa_f = {(e.ptag & mask_f(e.size)) | (va[31:12] & ~mask_f(e.size)), va[11:0]};
    endfunction
    function automatic logic perm_f(input mtl_pkg::mtl_entry_t e, input mtl_pkg::mtl_req_t r, input logic [31:0] dacr);
        logic [31:0] sh;
        logic bad;
        sh = dacr >> {e.dom, 1'b0};
        bad = (e.ap == 2'h0) || (!r.priv && !e.ap[1]) || (r.wr && (e.apx || (!r.priv && e.ap == 2'h2)));
        case (sh[1:0])
            2'h1: perm_f = bad;
            2'h3: perm_f = 1'b0;
            default: perm_f = 1'b1;
        endcase
    endfunction

    // ----------------------------------------
    // State.
    // ----------------------------------------
    mtl_pkg::mtl_state_t state;
    mtl_pkg::mtl_req_t cur;
    mtl_pkg::mtl_entry_t fill_e;
    logic cur_side;
    logic fill_v;
    logic fill_main;
    logic fill_side;
    logic [3:0] dom1;
    logic [31:0] ptb;
    logic [7:0] asid;
    logic [31:0] dacr;
    logic [31:0] ttb;
    logic lock_mode;
    logic [2:0] lptr;
    logic rr;
    logic [4:0] uptr [2];
    logic [31:0] uval [2];
    logic [31:0] mval [2];
    logic [3:0] lval;
    logic [3:0] lck;
    mtl_pkg::mtl_entry_t utlb [2][`MTL_UTLB_N];
    mtl_pkg::mtl_entry_t mt [2][`MTL_SETS];
    mtl_pkg::mtl_entry_t lk [`MTL_LOCK_N];

    // ----------------------------------------
    // Look-up and walk decode.
    // ----------------------------------------
    wire sel_side = d_valid;
    wire mtl_pkg::mtl_req_t sel_req = d_valid ? d_req : i_req;
    wire take = (state == mtl_pkg::MTL_IDLE) && !rsp_valid && (i_valid || d_valid);
    wire [4:0] midx = cur.va[16:12];
    wire [4:0] fidx = fill_e.vtag[4:0];
    wire to_lock = lock_mode && (lptr < 3'h4);
    wire inv_all = cp_valid && (cp_op == mtl_pkg::MTL_OP_INV_ALL);
    wire inv_asid = cp_valid && (cp_op == mtl_pkg::MTL_OP_INV_ASID);
    wire unlock = cp_valid && (cp_op == mtl_pkg::MTL_OP_UNLOCK);
    wire walk_dis = ttb[`MTL_TTB_WDIS];
    logic [31:0] uhit;
    logic [3:0] lhit;
    logic [1:0] whit;
    mtl_pkg::mtl_entry_t uent;
    mtl_pkg::mtl_entry_t ment;
    mtl_pkg::mtl_entry_t sent;
    mtl_pkg::mtl_entry_t pent;

    genvar gi;
    generate
        for (gi = 0; gi < `MTL_UTLB_N; gi++)
        begin : g_uhit
            assign uhit[gi] = uval[sel_side][gi] && hit_f(utlb[sel_side][gi], sel_req, asid);
        end
        for (gi = 0; gi < `MTL_LOCK_N; gi++)
        begin : g_lhit
            assign lhit[gi] = lval[gi] && hit_f(lk[gi], cur, asid);
        end
        for (gi = 0; gi < 2; gi++)
        begin : g_whit
            assign whit[gi] = mval[gi][midx] && hit_f(mt[gi][midx], cur, asid);
        end
    endgenerate

    always_comb
    begin
        uent = utlb[sel_side][0];
        for (int k = `MTL_UTLB_N - 1; k >= 0; k--)
        begin
            if (uhit[k])
            begin
                uent = utlb[sel_side][k];
            end
        end
        ment = whit[0] ? mt[0][midx] : mt[1][midx];
        for (int k = `MTL_LOCK_N - 1; k >= 0; k--)
        begin
            if (lhit[k])
            begin
                ment = lk[k];
            end
        end
    end

    wire uhit_any = |uhit;
    wire mhit = (|lhit) || (|whit);
    wire l1_sect = walk_rdata[1:0] == 2'h2;
    wire l1_coarse = walk_rdata[1:0] == 2'h1;
    wire l1_super = walk_rdata[`MTL_L1_SUPER];
    wire l2_small = walk_rdata[1];
    assign sent = '{vtag: cur.va[31:12], ptag: walk_rdata[31:12],
        size: l1_super ? mtl_pkg::MTL_SZ_16M : mtl_pkg::MTL_SZ_1M,
        dom: l1_super ? 4'h0 : walk_rdata[8:5], ap: walk_rdata[11:10], apx: walk_rdata[`MTL_L1_APX],
        glob: !walk_rdata[`MTL_L1_NG], nstag: cur.ns, asid: asid, cacheable: walk_rdata[3]};
    assign pent = '{vtag: cur.va[31:12], ptag: walk_rdata[31:12],
        size: l2_small ? mtl_pkg::MTL_SZ_4K : mtl_pkg::MTL_SZ_64K,
        dom: dom1, ap: walk_rdata[5:4], apx: walk_rdata[`MTL_L2_APX],
        glob: !walk_rdata[`MTL_L2_NG], nstag: cur.ns, asid: asid, cacheable: walk_rdata[3]};
    wire in_l1 = state == mtl_pkg::MTL_WAIT1;
    wire walk_fault = walk_err || (in_l1 ? !(l1_sect || l1_coarse) : walk_rdata[1:0] == 2'h0);
    wire mtl_pkg::mtl_entry_t went = in_l1 ? sent : pent;
    wire mtl_pkg::mtl_entry_t he = (state == mtl_pkg::MTL_IDLE) ? uent : (state == mtl_pkg::MTL_MAIN) ? ment : went;
    wire mtl_pkg::mtl_req_t hr = (state == mtl_pkg::MTL_IDLE) ? sel_req : cur;
    wire hside = (state == mtl_pkg::MTL_IDLE) ? sel_side : cur_side;
    wire mtl_pkg::mtl_rsp_t next_rsp = '{side: hside, abort: perm_f(he, hr, dacr),
        cacheable: he.cacheable, pa: pa_f(he, hr.va)};
    wire mtl_pkg::mtl_rsp_t fault_rsp = '{side: cur_side, abort: 1'b1, cacheable: 1'b0, pa: cur.va};

    // ----------------------------------------
    // Translation sequence.
    // ----------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            state <= mtl_pkg::MTL_IDLE;
            busy <= 1'b0;
            rsp_valid <= 1'b0;
            rsp <= '0;
            walk_req <= 1'b0;
            walk_addr <= '0;
            walk_cacheable <= 1'b0;
            fill_v <= 1'b0;
            fill_main <= 1'b0;
            fill_side <= 1'b0;
            fill_e <= '0;
            cur <= '0;
            cur_side <= 1'b0;
            dom1 <= 4'h0;
            ptb <= '0;
        end
        else
        begin
            rsp_valid <= 1'b0;
            fill_v <= 1'b0;
            case (state)
                mtl_pkg::MTL_IDLE:
                begin
                    if (take)
                    begin
                        cur <= sel_req;
                        cur_side <= sel_side;
                        if (uhit_any)
                        begin
                            rsp_valid <= 1'b1;
                            rsp <= next_rsp;
                        end
                        else
                        begin
                            busy <= 1'b1;
                            state <= mtl_pkg::MTL_MAIN;
                        end
                    end
                end
                mtl_pkg::MTL_MAIN:
                begin
                    if (mhit)
                    begin
                        rsp_valid <= 1'b1;
                        rsp <= next_rsp;
                        fill_v <= 1'b1;
                        fill_main <= 1'b0;
                        fill_side <= cur_side;
                        fill_e <= ment;
                        busy <= 1'b0;
                        state <= mtl_pkg::MTL_IDLE;
                    end
                    else if (walk_dis)
                    begin
                        rsp_valid <= 1'b1;
                        rsp <= fault_rsp;
                        busy <= 1'b0;
                        state <= mtl_pkg::MTL_IDLE;
                    end
                    else
                    begin
                        walk_req <= 1'b1;
                        walk_addr <= {ttb[31:14], cur.va[31:20], 2'h0};
                        walk_cacheable <= ttb[`MTL_TTB_WB];
                        state <= mtl_pkg::MTL_WAIT1;
                    end
                end
                mtl_pkg::MTL_WALK2:
                begin
                    walk_req <= 1'b1;
                    walk_addr <= ptb;
                    state <= mtl_pkg::MTL_WAIT2;
                end
                mtl_pkg::MTL_WAIT1, mtl_pkg::MTL_WAIT2:
                begin
                    if (walk_rvalid)
                    begin
                        walk_req <= 1'b0;
                        if (in_l1 && l1_coarse && !walk_err)
                        begin
                            dom1 <= walk_rdata[8:5];
                            ptb <= {walk_rdata[31:10], cur.va[19:12], 2'h0};
                            state <= mtl_pkg::MTL_WALK2;
                        end
                        else
                        begin
                            rsp_valid <= 1'b1;
                            rsp <= walk_fault ? fault_rsp : next_rsp;
                            fill_v <= !walk_fault;
                            fill_main <= 1'b1;
                            fill_side <= cur_side;
                            fill_e <= went;
                            busy <= 1'b0;
                            state <= mtl_pkg::MTL_IDLE;
                        end
                    end
                end
                default:
                begin
                    state <= mtl_pkg::MTL_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Coprocessor port.
    // ----------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            asid <= `MTL_ASID_RST;
            dacr <= `MTL_DACR_RST;
            ttb <= `MTL_TTB_RST;
            lock_mode <= 1'b0;
        end
        else if (cp_valid)
        begin
            case (cp_op)
                mtl_pkg::MTL_OP_ASID: asid <= cp_wdata[7:0];
                mtl_pkg::MTL_OP_DOMAIN: dacr <= cp_wdata;
                mtl_pkg::MTL_OP_TTB: ttb <= cp_wdata;
                mtl_pkg::MTL_OP_LOCK_MODE: lock_mode <= cp_wdata[0];
                default: lock_mode <= lock_mode;
            endcase
        end
    end

    // ----------------------------------------
    // Refill, replacement and invalidation.
    // ----------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            rr <= 1'b0;
            lptr <= 3'h0;
            uptr[0] <= 5'h00;
            uptr[1] <= 5'h00;
        end
        else
        begin
            if (fill_v)
            begin
                uptr[fill_side] <= uptr[fill_side] + 5'h01;
            end
            if (unlock)
            begin
                lptr <= 3'h0;
            end
            else if (fill_v && fill_main && to_lock)
            begin
                lptr <= lptr + 3'h1;
            end
            else if (fill_v && fill_main)
            begin
                rr <= !rr;
            end
        end
    end

    generate
        for (gi = 0; gi < `MTL_UTLB_N; gi++)
        begin : g_ent
            for (genvar s = 0; s < 2; s++)
            begin : g_side
                wire ufill = fill_v && (fill_side == s) && (uptr[s] == gi);
                wire mfill = fill_v && fill_main && !to_lock && (rr == s) && (fidx == gi);
                always_ff @(posedge mclk)
                begin
                    if (!rstn || cp_valid)
                    begin
                        uval[s][gi] <= 1'b0;
                    end
                    else if (ufill)
                    begin
                        uval[s][gi] <= 1'b1;
                    end
                    if (!rstn)
                    begin
                        mval[s][gi] <= 1'b0;
                    end
                    else if (mfill)
                    begin
                        mval[s][gi] <= 1'b1;
                    end
                    else if (inv_all || (inv_asid && !mt[s][gi].glob && mt[s][gi].asid == cp_wdata[7:0]))
                    begin
                        mval[s][gi] <= 1'b0;
                    end
                end
                always_ff @(posedge mclk)
                begin
                    if (ufill)
                    begin
                        utlb[s][gi] <= fill_e;
                    end
                    if (mfill)
                    begin
                        mt[s][gi] <= fill_e;
                    end
                end
            end
        end
        for (gi = 0; gi < `MTL_LOCK_N; gi++)
        begin : g_lock
            wire lfill = fill_v && fill_main && to_lock && (lptr == gi);
            always_ff @(posedge mclk)
            begin
                if (!rstn || unlock)
                begin
                    lck[gi] <= 1'b0;
                end
                else if (lfill)
                begin
                    lck[gi] <= 1'b1;
                end
                if (!rstn)
                begin
                    lval[gi] <= 1'b0;
                end
                else if (lfill)
                begin
                    lval[gi] <= 1'b1;
                end
                else if ((inv_all || (inv_asid && !lk[gi].glob && lk[gi].asid == cp_wdata[7:0])) && !lck[gi])
                begin
                    lval[gi] <= 1'b0;
                end
                if (lfill)
                begin
                    lk[gi] <= fill_e;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Checks.
    // ----------------------------------------
    a_rsp_single: assert property (@(posedge mclk) disable iff (!rstn) rsp_valid |=> !rsp_valid)
        else $error("answer held longer than one cycle");
    a_micro_fast: assert property (@(posedge mclk) disable iff (!rstn) take && uhit_any |=> rsp_valid)
        else $error("micro hit not answered next cycle");
    a_micro_abort: assert property (@(posedge mclk) disable iff (!rstn)
        take && uhit_any && perm_f(uent, sel_req, dacr) |=> rsp.abort)
        else $error("failed permission not aborted");
    a_walk_start: assert property (@(posedge mclk) disable iff (!rstn)
        state == mtl_pkg::MTL_MAIN && !mhit && !walk_dis |=> walk_req && state == mtl_pkg::MTL_WAIT1)
        else $error("main miss did not start a walk");
    a_walk_off: assert property (@(posedge mclk) disable iff (!rstn)
        state == mtl_pkg::MTL_MAIN && !mhit && walk_dis |=> rsp_valid && rsp.abort && !walk_req)
        else $error("disabled walk did not fault");
    a_walk_route: assert property (@(posedge mclk) disable iff (!rstn)
        walk_req && state == mtl_pkg::MTL_WAIT1 |->
        walk_cacheable == ttb[`MTL_TTB_WB] && walk_addr[31:14] == ttb[31:14])
        else $error("walk read misrouted");
    a_micro_flush: assert property (@(posedge mclk) disable iff (!rstn)
        cp_valid |=> uval[0] == '0 && uval[1] == '0)
        else $error("micro TLB not flushed");
    a_lock_kept: assert property (@(posedge mclk) disable iff (!rstn)
        lck[0] && lval[0] && !unlock |=> lck[0] && lval[0] && $stable(lk[0]))
        else $error("locked entry lost");
    a_lock_count: assert property (@(posedge mclk) disable iff (!rstn) lptr <= 3'h4)
        else $error("lock pointer past lockable entries");
endmodule

// ==== dv/mtl_walk_mem.sv ====
// Walk memory model answering the table reads of the translation unit.
// Assumes the bench loads descriptors into mem and sets latency and error.
`timescale 1ns/1ps
module mtl_walk_mem (
    input wire logic mclk,
    input wire logic walk_req,
    input wire logic [31:0] walk_addr,
    input wire logic [3:0] lat,
    input wire logic err_on,
    output logic walk_rvalid,
    output logic [31:0] walk_rdata,
    output logic walk_err
);
    logic [31:0] mem [logic [31:0]];
    logic [3:0] cnt = 4'h0;
    initial
    begin
        walk_rvalid = 1'b0;
        walk_rdata = 32'h0000_0000;
        walk_err = 1'b0;
    end
    // ----
    // Data toggles outside a valid beat, so stale data never looks good.
    // ----
    always @(posedge mclk)
    begin
        walk_rvalid <= 1'b0;
        walk_err <= 1'b0;
        walk_rdata <= ~walk_rdata;
        if (walk_req && !walk_rvalid && cnt < lat)
            cnt <= cnt + 4'h1;
        else if (walk_req && !walk_rvalid)
        begin
            cnt <= 4'h0;
            walk_rvalid <= 1'b1;
            walk_rdata <= mem.exists(walk_addr) ? mem[walk_addr] : 32'h0000_0000;
            walk_err <= err_on;
        end
    end
endmodule

// ==== dv/mtl_mmu_tb_top.sv ====
// Self-checking bench of the two-level translation unit.
// Assumes the walk memory model on the table-read port and one 100 MHz clock.
`timescale 1ns/1ps
module mtl_mmu_tb_top;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic i_valid = 1'b0;
    logic d_valid = 1'b0;
    mtl_pkg::mtl_req_t i_req = '0;
    mtl_pkg::mtl_req_t d_req = '0;
    logic cp_valid = 1'b0;
    mtl_pkg::mtl_cpop_t cp_op = mtl_pkg::MTL_OP_NOP;
    logic [31:0] cp_wdata = 32'h0000_0000;
    logic walk_rvalid, walk_err, busy, rsp_valid, walk_req, walk_cacheable, wreq_d;
    logic [31:0] walk_rdata, walk_addr;
    logic [31:0] seed = 32'h0000_0002;
    logic [3:0] lat = 4'h0;
    logic err_on = 1'b0;
    mtl_pkg::mtl_rsp_t rsp, e;
    mtl_pkg::mtl_rsp_t exp_q[$];
    logic [32:0] addr_q[$];
    int n_mismatch = 0;
    int n_tests = 0;
    always #5 mclk = ~mclk;
    mtl_mmu mtl_mmu_inst (.mclk(mclk), .rstn(rstn), .i_valid(i_valid), .i_req(i_req), .d_valid(d_valid),
        .d_req(d_req), .cp_valid(cp_valid), .cp_op(cp_op), .cp_wdata(cp_wdata), .walk_rvalid(walk_rvalid),
        .walk_rdata(walk_rdata), .walk_err(walk_err), .busy(busy), .rsp_valid(rsp_valid), .rsp(rsp),
        .walk_req(walk_req), .walk_addr(walk_addr), .walk_cacheable(walk_cacheable));
    mtl_walk_mem mtl_walk_mem_inst (.mclk(mclk), .walk_req(walk_req), .walk_addr(walk_addr), .lat(lat),
        .err_on(err_on), .walk_rvalid(walk_rvalid), .walk_rdata(walk_rdata), .walk_err(walk_err));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [31:0] l1(input logic [31:0] va);
        return {18'h0_0001, va[31:20], 2'h0};
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cp(input mtl_pkg::mtl_cpop_t op, input logic [31:0] wd);
        cp_valid <= 1'b1; // Maintenance port.
        cp_op <= op;
        cp_wdata <= wd;
        @(posedge mclk);
        cp_valid <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic ld(input logic [31:0] a, input logic [31:0] d);
        mtl_walk_mem_inst.mem[a] = d;
        addr_q.push_back({1'b1, a});
    endtask
    task automatic acc(input logic side, input logic [31:0] va, input logic priv, input logic ns,
        input logic ab, input logic ca, input logic [31:0] pa, input int lat_exp);
        mtl_pkg::mtl_req_t r;
        int n;
        seed = xs(seed);
        lat <= seed[3:0] & 4'h3;
        r = {va[31:12], seed[27:16], priv, seed[31], ns};
        exp_q.push_back({side, ab, ca, pa[31:12], seed[27:16]});
        i_req <= r;
        d_req <= r;
        i_valid <= !side;
        d_valid <= side;
        n = 0;
        do
        begin
            @(negedge mclk);
            n++;
            if (n == 2)
                check(64'(busy), 64'(lat_exp != 2)); // Busy on micro miss.
        end
        while (rsp_valid !== 1'b1 && n < 300);
        if (n >= 300)
        begin
            n_mismatch++;
            close_out();
        end
        if (lat_exp > 0)
            check(64'(n), 64'(lat_exp)); // Hit latency.
        @(posedge mclk);
        i_valid <= 1'b0;
        d_valid <= 1'b0;
        @(posedge mclk);
        check(64'(addr_q.size()), 64'h0); // All reads done.
    endtask
    // ----
    // Monitor of table reads and answers.
    // ----
    always @(negedge mclk)
    begin
        if (walk_req === 1'b1 && wreq_d !== 1'b1)
        begin
            if (addr_q.size() == 0)
                check(64'(walk_addr), 64'h1_0000_0000); // Unexpected walk.
            else
                check(64'({walk_cacheable, walk_addr}), 64'(addr_q.pop_front())); // Read.
        end
        wreq_d = walk_req;
        if (rsp_valid === 1'b1 && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            if (e.abort)
                check(64'({rsp.side, rsp.abort}), 64'({e.side, e.abort})); // Abort.
            else
                check(64'(rsp), 64'(e)); // Answer.
        end
        else if (rsp_valid === 1'b1)
            check(64'(rsp), 64'h100_0000_0000); // Unexpected answer.
    end
    initial
    begin
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        cp(mtl_pkg::MTL_OP_TTB, 32'h0000_4001);
        cp(mtl_pkg::MTL_OP_DOMAIN, 32'h0000_0c01);
        ld(l1(32'h1234_5000), 32'habc0_0c0a);
        acc(1, 32'h1234_5000, 0, 0, 0, 1, 32'habc4_5000, 0);
        acc(1, 32'h1234_5000, 0, 0, 0, 1, 32'habc4_5000, 2); // Micro hit.
        acc(0, 32'h1234_5000, 0, 0, 0, 1, 32'habc4_5000, 3); // Unified main.
        ld(l1(32'h2000_0000), 32'h3000_0402);
        acc(1, 32'h2000_0000, 1, 0, 0, 0, 32'h3000_0000, 0);
        acc(1, 32'h2000_0000, 0, 0, 1, 0, 32'h0000_0000, 2); // User denied.
        ld(l1(32'h0030_1000), 32'h0010_02a1);
        ld(32'h0010_0004, 32'h7654_303a);
        acc(0, 32'h0030_1000, 1, 0, 0, 1, 32'h7654_3000, 0); // Small page.
        ld(l1(32'h0031_5000), 32'h0010_02a1);
        ld(32'h0010_0054, 32'h1234_0031);
        acc(0, 32'h0031_5000, 1, 0, 0, 0, 32'h1234_5000, 0); // Large page.
        ld(l1(32'h0e56_7000), 32'h0d04_0c02);
        acc(1, 32'h0e56_7000, 0, 0, 0, 0, 32'h0d56_7000, 0); // Supersection.
        cp(mtl_pkg::MTL_OP_DOMAIN, 32'h0000_0001);
        acc(0, 32'h0030_1000, 1, 0, 1, 0, 32'h0000_0000, 3); // No access.
        cp(mtl_pkg::MTL_OP_DOMAIN, 32'h0000_0003);
        acc(1, 32'h2000_0000, 0, 0, 0, 0, 32'h3000_0000, 3); // Manager.
        cp(mtl_pkg::MTL_OP_DOMAIN, 32'h0000_0001);
        cp(mtl_pkg::MTL_OP_ASID, 32'h0000_0001);
        ld(l1(32'h5000_0000), 32'h5102_0c02);
        acc(1, 32'h5000_0000, 0, 0, 0, 0, 32'h5100_0000, 0);
        cp(mtl_pkg::MTL_OP_ASID, 32'h0000_0002);
        ld(l1(32'h5000_0000), 32'h5102_0c02);
        acc(1, 32'h5000_0000, 0, 0, 0, 0, 32'h5100_0000, 0); // Other space.
        acc(1, 32'h1234_5000, 0, 0, 0, 1, 32'habc4_5000, 3); // Global.
        ld(l1(32'h1234_5000), 32'habc0_0c0a);
        acc(1, 32'h1234_5000, 0, 1, 0, 1, 32'habc4_5000, 0); // Security tag.
        cp(mtl_pkg::MTL_OP_INV_ASID, 32'h0000_0002);
        ld(l1(32'h5000_0000), 32'h5102_0c02);
        acc(1, 32'h5000_0000, 0, 0, 0, 0, 32'h5100_0000, 0);
        err_on <= 1'b1;
        ld(l1(32'h6000_0000), 32'h6000_0c02);
        acc(1, 32'h6000_0000, 0, 0, 1, 0, 32'h0000_0000, 0); // Read error.
        err_on <= 1'b0;
        ld(l1(32'h3000_0000), 32'h3000_0c03);
        acc(0, 32'h3000_0000, 1, 0, 1, 0, 32'h0000_0000, 0); // Descriptor fault.
        cp(mtl_pkg::MTL_OP_LOCK_MODE, 32'h0000_0001);
        ld(l1(32'h4000_0000), 32'h4000_0c02);
        acc(1, 32'h4000_0000, 0, 0, 0, 0, 32'h4000_0000, 0);
        cp(mtl_pkg::MTL_OP_LOCK_MODE, 32'h0000_0000);
        for (int k = 8; k < 12; k++)
        begin
            ld(l1(32'(k) << 28), (32'(k) << 28) | 32'h0000_0c02);
            acc(1, 32'(k) << 28, 0, 0, 0, 0, 32'(k) << 28, 0);
        end
        cp(mtl_pkg::MTL_OP_INV_ALL, 32'h0000_0000);
        acc(1, 32'h4000_0000, 0, 0, 0, 0, 32'h4000_0000, 3); // Locked kept.
        cp(mtl_pkg::MTL_OP_UNLOCK, 32'h0000_0000);
        cp(mtl_pkg::MTL_OP_NOP, 32'h0000_0000);
        cp(mtl_pkg::MTL_OP_INV_ALL, 32'h0000_0000);
        ld(l1(32'h4000_0000), 32'h4000_0c02);
        acc(1, 32'h4000_0000, 0, 0, 0, 0, 32'h4000_0000, 0); // Unlocked gone.
        cp(mtl_pkg::MTL_OP_TTB, 32'h0000_4003);
        acc(1, 32'h7000_0000, 0, 0, 1, 0, 32'h0000_0000, 3); // Walks off.
        check(64'(exp_q.size()), 64'h0); // All answers seen.
        close_out();
    end
endmodule
